// *** core/eeprom_cmd_pkg.sv ***
// Constants and types for the serial EEPROM command port.
// Assumes the port runs on one system clock that oversamples the serial pins.
`default_nettype none
package eeprom_cmd_pkg;
    localparam int OPCODE_BITS = 8;
    localparam logic [2:0] OP_LATCH_SET = 3'h6;
    localparam logic [2:0] OP_LATCH_CLEAR = 3'h4;
    localparam logic [2:0] OP_STATUS_READ = 3'h5;
    localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
    localparam logic [2:0] OP_ARRAY_READ = 3'h3;
    localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
    localparam int ST_PROTECT_ENABLE_POS = 7;
    localparam int ST_BLOCK_HI_POS = 3;
    localparam int ST_BLOCK_LO_POS = 2;
    localparam int ST_LATCH_POS = 1;
    localparam int ST_BUSY_POS = 0;
    localparam logic [7:0] STATUS_BUSY_READ = 8'hFF;
    localparam logic RESET_LATCH = 1'b0;
    localparam logic [1:0] RESET_BLOCK = 2'h0;
    localparam logic RESET_PROTECT_ENABLE = 1'b0;
    localparam int CLK_MHZ = 40;
    localparam int WRITE_CYCLE_MS = 10;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_RUN = 3'b001,
        ST_SHIFT_OUT = 3'b011,
        ST_IGNORE = 3'b010
    } port_state_e;
endpackage
`default_nettype wire

// *** core/two_entry_buffer.sv ***
// Two-entry valid/ready buffer.
// Assumes both sides on the same clock.
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    initial begin
        if (WIDTH < 1) begin
            $error("WIDTH must be at least 1");
        end
    end

    assign o_ready = (count != 2'h2);
    assign o_valid = (count != 2'h0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_ptr];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end
endmodule
`default_nettype wire

// *** core/eeprom_cmd_port.sv ***
// Serial command port of a byte-wide serial EEPROM, slave side.
// Assumes serial pins are asynchronous and oversampled by i_sys_clk.
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_port #(
    parameter int WRITE_CYCLE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLE_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Serial pins
    input wire logic i_select_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    input wire logic i_pause_n,
    input wire logic i_protect_n,
    // Array-side byte stream
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic [7:0] o_rx_data,
    output logic o_array_read,
    output logic o_array_write,
    output logic o_write_start,
    // Status view
    output logic [7:0] o_status,
    output logic [1:0] o_protect_level,
    output logic o_busy
);
    logic [1:0] sel_sync;
    logic [1:0] clk_sync;
    logic [1:0] sdi_sync;
    logic [1:0] pause_sync;
    logic [1:0] prot_sync;
    logic sel_n;
    logic sclk_q;
    logic sclk_prev;
    logic sel_prev;
    logic sdi_s;
    logic paused;
    logic prot_n;
    logic rise;
    logic fall;
    logic sel_fall;
    logic sel_rise;
    logic active;
    eeprom_cmd_pkg::port_state_e state;
    logic [7:0] shift_in;
    logic [2:0] bit_cnt;
    logic [7:0] opcode;
    logic [7:0] shift_out;
    logic [2:0] out_cnt;
    logic sdo;
    logic drive;
    logic latch;
    logic [1:0] block;
    logic protect_en;
    logic [7:0] new_status;
    logic status_wr_pend;
    logic status_wr_abort;
    logic busy;
    logic [31:0] busy_cnt;
    logic hw_protected;
    logic [7:0] status_live;
    logic [7:0] status_view;
    logic opcode_ok;
    logic [2:0] op;
    logic [7:0] next_byte;
    logic byte_done;
    logic prot_prev;
    eeprom_cmd_pkg::port_state_e next_state;
    logic status_wr_go;
    logic array_wr_go;
    logic rx_push;

    initial begin
        if (WRITE_CYCLE_CYCLES < 1) begin
            $error("WRITE_CYCLE_CYCLES must be at least 1");
        end
        if (eeprom_cmd_pkg::OPCODE_BITS != 8) begin
            $error("op-code register must be eight bits");
        end
    end

    // Two-stage synchronisers; serial clock is only sampled
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_sync <= 2'h3;
            clk_sync <= 2'h0;
            sdi_sync <= 2'h0;
            pause_sync <= 2'h3;
            prot_sync <= 2'h3;
        end else begin
            sel_sync <= {sel_sync[0], i_select_n};
            clk_sync <= {clk_sync[0], i_sclk};
            sdi_sync <= {sdi_sync[0], i_sdi};
            pause_sync <= {pause_sync[0], i_pause_n};
            prot_sync <= {prot_sync[0], i_protect_n};
        end
    end

    assign sel_n = sel_sync[1];
    assign sclk_q = clk_sync[1];
    assign sdi_s = sdi_sync[1];
    assign prot_n = prot_sync[1];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev <= 1'b0;
            sel_prev <= 1'b1;
            prot_prev <= 1'b1;
        end else begin
            sclk_prev <= sclk_q;
            sel_prev <= sel_n;
            prot_prev <= prot_n;
        end
    end

    // Pause state changes only while the serial clock is low; deselect clears it at any time
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            paused <= 1'b0;
        end else if (sel_n) begin
            paused <= 1'b0;
        end else if (!sclk_q) begin
            paused <= ~pause_sync[1];
        end
    end

    assign sel_fall = sel_prev && !sel_n;
    assign sel_rise = !sel_prev && sel_n;
    assign active = !sel_n && !paused;
    assign rise = active && sclk_q && !sclk_prev;
    assign fall = active && !sclk_q && sclk_prev;

    assign next_byte = {shift_in[6:0], sdi_s};
    assign byte_done = rise && (bit_cnt == 3'h7);
    assign op = next_byte[2:0];
    assign opcode_ok = (next_byte[7:4] == 4'h0) && (op != 3'h0) && (op != 3'h7);
    assign hw_protected = protect_en && !prot_n;

    // Bit counter and input shifter
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_in <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (sel_fall) begin
            shift_in <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (rise && state != eeprom_cmd_pkg::ST_IGNORE) begin
            shift_in <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Command sequencing
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= eeprom_cmd_pkg::ST_OPCODE;
            opcode <= 8'h00;
        end else if (sel_fall) begin
            state <= eeprom_cmd_pkg::ST_OPCODE;
        end else if (byte_done && state == eeprom_cmd_pkg::ST_OPCODE) begin
            opcode <= next_byte;
            state <= next_state;
        end
    end

    // State that follows the op-code byte
    always_comb begin
        case (op)
            eeprom_cmd_pkg::OP_LATCH_SET,
            eeprom_cmd_pkg::OP_LATCH_CLEAR: begin
                next_state = eeprom_cmd_pkg::ST_RUN;
            end
            eeprom_cmd_pkg::OP_STATUS_READ: begin
                next_state = eeprom_cmd_pkg::ST_SHIFT_OUT;
            end
            eeprom_cmd_pkg::OP_ARRAY_READ: begin
                next_state = eeprom_cmd_pkg::ST_SHIFT_OUT;
            end
            eeprom_cmd_pkg::OP_STATUS_WRITE,
            eeprom_cmd_pkg::OP_ARRAY_WRITE: begin
                if (latch) begin
                    next_state = eeprom_cmd_pkg::ST_RUN;
                end else begin
                    next_state = eeprom_cmd_pkg::ST_IGNORE;
                end
            end
            default: begin
                next_state = eeprom_cmd_pkg::ST_IGNORE;
            end
        endcase
        if (!opcode_ok) begin
            next_state = eeprom_cmd_pkg::ST_IGNORE;
        end else if (busy && op != eeprom_cmd_pkg::OP_STATUS_READ) begin
            next_state = eeprom_cmd_pkg::ST_IGNORE;
        end
    end

    assign o_array_read = (state == eeprom_cmd_pkg::ST_SHIFT_OUT) &&
        (opcode[2:0] == eeprom_cmd_pkg::OP_ARRAY_READ) && !sel_n;
    assign o_array_write = (state == eeprom_cmd_pkg::ST_RUN) &&
        (opcode[2:0] == eeprom_cmd_pkg::OP_ARRAY_WRITE) && !sel_n;

    // Bytes after the op-code, except in status reads and ignored commands, go to the array side through a buffer
    assign rx_push = byte_done && state != eeprom_cmd_pkg::ST_OPCODE &&
        state != eeprom_cmd_pkg::ST_IGNORE &&
        opcode[2:0] != eeprom_cmd_pkg::OP_STATUS_READ;
    // A byte arriving with both entries full is dropped
    two_entry_buffer #(
        .WIDTH(8)
    ) u_rx_buf (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_valid(rx_push),
        .o_ready(),
        .i_data(next_byte),
        .o_valid(o_rx_valid),
        .i_ready(i_rx_ready),
        .o_data(o_rx_data)
    );

    // Write latch, status write capture and abort
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            latch <= eeprom_cmd_pkg::RESET_LATCH;
            status_wr_pend <= 1'b0;
            status_wr_abort <= 1'b0;
            new_status <= 8'h00;
        end else begin
            if (sel_fall) begin
                status_wr_pend <= 1'b0;
                status_wr_abort <= 1'b0;
            end
            if (byte_done && state == eeprom_cmd_pkg::ST_OPCODE && opcode_ok && !busy) begin
                if (op == eeprom_cmd_pkg::OP_LATCH_SET) begin
                    latch <= 1'b1;
                end
                if (op == eeprom_cmd_pkg::OP_LATCH_CLEAR) begin
                    latch <= 1'b0;
                end
            end
            if (byte_done && state == eeprom_cmd_pkg::ST_RUN &&
                opcode[2:0] == eeprom_cmd_pkg::OP_STATUS_WRITE && !status_wr_pend) begin
                new_status <= next_byte;
                status_wr_pend <= 1'b1;
                if (hw_protected) begin
                    status_wr_abort <= 1'b1;
                end
            end
            if (!sel_n && prot_prev && !prot_n && protect_en &&
                state == eeprom_cmd_pkg::ST_RUN &&
                opcode[2:0] == eeprom_cmd_pkg::OP_STATUS_WRITE) begin
                status_wr_abort <= 1'b1;
            end
            if (sel_rise && status_wr_pend) begin
                status_wr_pend <= 1'b0;
            end
            if (busy && busy_cnt == 32'h0000_0001) begin
                latch <= 1'b0;
            end
        end
    end

    // Internal write cycle timer
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy <= 1'b0;
            busy_cnt <= 32'h0000_0000;
            block <= eeprom_cmd_pkg::RESET_BLOCK;
            protect_en <= eeprom_cmd_pkg::RESET_PROTECT_ENABLE;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 32'h0000_0001;
            if (busy_cnt == 32'h0000_0001) begin
                busy <= 1'b0;
            end
        end else if (status_wr_go) begin
            busy <= 1'b1;
            busy_cnt <= WRITE_CYCLE_CYCLES[31:0];
            block <= {new_status[eeprom_cmd_pkg::ST_BLOCK_HI_POS],
                      new_status[eeprom_cmd_pkg::ST_BLOCK_LO_POS]};
            protect_en <= new_status[eeprom_cmd_pkg::ST_PROTECT_ENABLE_POS];
        end else if (array_wr_go) begin
            busy <= 1'b1;
            busy_cnt <= WRITE_CYCLE_CYCLES[31:0];
        end
    end

    // Write cycles start on the select rise that ends a complete command
    assign status_wr_go = sel_rise && status_wr_pend && !status_wr_abort &&
        !hw_protected;
    assign array_wr_go = sel_rise && latch && state == eeprom_cmd_pkg::ST_RUN &&
        opcode[2:0] == eeprom_cmd_pkg::OP_ARRAY_WRITE;
    assign o_write_start = status_wr_go && !busy;

    // Live status layout
    always_comb begin
        status_live = 8'h00;
        status_live[eeprom_cmd_pkg::ST_PROTECT_ENABLE_POS] = protect_en;
        status_live[eeprom_cmd_pkg::ST_BLOCK_HI_POS] = block[1];
        status_live[eeprom_cmd_pkg::ST_BLOCK_LO_POS] = block[0];
        status_live[eeprom_cmd_pkg::ST_LATCH_POS] = latch;
        status_live[eeprom_cmd_pkg::ST_BUSY_POS] = busy;
    end

    assign status_view = busy ? eeprom_cmd_pkg::STATUS_BUSY_READ : status_live;

    // Output shifter: loads status on a status-read op-code, advances on falling edges
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_out <= 8'h00;
            out_cnt <= 3'h0;
            sdo <= 1'b0;
            drive <= 1'b0;
        end else if (sel_n || state == eeprom_cmd_pkg::ST_IGNORE) begin
            drive <= 1'b0;
            out_cnt <= 3'h0;
        end else if (byte_done && state == eeprom_cmd_pkg::ST_OPCODE &&
                     opcode_ok && op == eeprom_cmd_pkg::OP_STATUS_READ) begin
            shift_out <= status_view;
            out_cnt <= 3'h0;
        end else if (fall && state == eeprom_cmd_pkg::ST_SHIFT_OUT) begin
            sdo <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            drive <= 1'b1;
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h7) begin
                shift_out <= status_view;
            end
        end
    end

    // Pin and status outputs
    assign o_sdo = sdo;
    assign o_sdo_oe_n = !(drive && active);
    assign o_status = status_live;
    assign o_protect_level = block;
    assign o_busy = busy;
endmodule
`default_nettype wire

// *** tb/eeprom_cmd_port_sva.sv ***
// Concurrent checks on the command port's pins and status view.
// Assumes binding to eeprom_cmd_port, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_port_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_select_n,
    input wire logic i_sclk,
    input wire logic i_rx_ready,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_n,
    input wire logic o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire logic o_array_read,
    input wire logic o_array_write,
    input wire logic o_write_start,
    input wire logic [7:0] o_status,
    input wire logic [1:0] o_protect_level,
    input wire logic o_busy
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    property p_desel;
        i_select_n [*4] |-> o_sdo_oe_n && !o_array_read && !o_array_write;
    endproperty
    a_desel: assert property (p_desel) else $error("port active while deselected");
    property p_sdo_hold;
        i_sclk [*3] |-> $stable(o_sdo);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("output moved in clock high");
    property p_unused;
        !o_busy |-> o_status[6:4] == 3'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused status bits set");
    property p_busy_bit;
        o_busy |-> o_status[0];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit low in write");
    property p_level;
        !o_busy |-> o_protect_level == o_status[3:2];
    endproperty
    a_level: assert property (p_level) else $error("protect level mismatch");
    property p_start;
        o_write_start |-> i_select_n ##[0:2] o_busy;
    endproperty
    a_start: assert property (p_start) else $error("write start without busy");
    property p_latch_end;
        $fell(o_busy) |-> ##[0:1] !o_status[1];
    endproperty
    a_latch_end: assert property (p_latch_end) else $error("latch kept after write");
    property p_rx_hold;
        o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("stalled byte lost");
    c_start: cover property (o_write_start);
    c_stall: cover property (o_rx_valid && !i_rx_ready);
    c_full: cover property (o_protect_level == 2'h3);
endmodule
bind eeprom_cmd_port eeprom_cmd_port_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_select_n(i_select_n), .i_sclk(i_sclk), .i_rx_ready(i_rx_ready), .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
    .o_array_read(o_array_read), .o_array_write(o_array_write),
    .o_write_start(o_write_start), .o_status(o_status), .o_protect_level(o_protect_level),
    .o_busy(o_busy));
`default_nettype wire

// *** tb/serial_master.sv ***
// Serial bus master model, clock idle low, 200 ns bit time.
// Assumes the port's output pin is resolved from its enable here.
`timescale 1ns/10ps
`default_nettype none
module serial_master (
    // Pins to the port
    output logic o_select_n,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_pause_n,
    input wire logic i_sdo,
    input wire logic i_sdo_oe_n
);
    logic alt = 1'b0;
    logic line;
    logic drove;
    initial begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
        o_pause_n = 1'b1;
        drove = 1'b0;
    end
    // Released line shows a changing pattern
    always #50 alt = ~alt;
    assign line = i_sdo_oe_n ? alt : i_sdo;
    task automatic start();
        drove = 1'b0;
        #100 o_select_n = 1'b0;
        #200;
    endtask
    task automatic stop();
        #100 o_select_n = 1'b1;
        #400;
    endtask
    // One byte each way; pause before bit pause_at when below 8
    task automatic xfer(input logic [7:0] tx, input int pause_at, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (i == pause_at) begin
                #100 o_pause_n = 1'b0;
                repeat (4) #100 o_sclk = ~o_sclk;
                o_sdi = ~o_sdi;
                #100 o_pause_n = 1'b1;
                #100;
            end
            o_sdi = tx[i];
            #100 o_sclk = 1'b1;
            #90 rx[i] = line;
            drove = drove | ~i_sdo_oe_n;
            #10 o_sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/eeprom_cmd_port_tb_top.sv ***
// Self-checking bench for the serial EEPROM command port.
// Assumes the master model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module eeprom_cmd_port_tb_top;
    localparam int WC = 400;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_protect_n = 1'b1;
    logic i_rx_ready = 1'b1;
    logic select_n, sclk, sdi, pause_n, sdo, sdo_oe_n;
    logic rx_valid, array_read, array_write, write_start, busy;
    logic [7:0] rx_data, status, got;
    logic [1:0] level;
    logic [7:0] bad_op [4] = '{8'h15, 8'h07, 8'h00, 8'h8D};
    logic [7:0] rx_exp [2] = '{8'hA5, 8'h3C};
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    eeprom_cmd_port #(.WRITE_CYCLE_CYCLES(WC)) u_eeprom_cmd_port (.i_sys_clk(i_sys_clk),
        .i_rst(i_rst), .i_select_n(select_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe_n(sdo_oe_n), .i_pause_n(pause_n), .i_protect_n(i_protect_n),
        .o_rx_valid(rx_valid), .i_rx_ready(i_rx_ready), .o_rx_data(rx_data),
        .o_array_read(array_read), .o_array_write(array_write), .o_write_start(write_start),
        .o_status(status), .o_protect_level(level), .o_busy(busy));
    serial_master u_serial_master (.o_select_n(select_n), .o_sclk(sclk), .o_sdi(sdi),
        .o_pause_n(pause_n), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n));
    task automatic end_sim();
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] act);
        num_checks++;
        if (act !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, act);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic act);
        chk8(name, {7'h00, exp}, {7'h00, act});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic pin(input logic v);
        tick(1);
        i_protect_n = v;
    endtask
    task automatic cmd1(input logic [7:0] op);
        u_serial_master.start();
        u_serial_master.xfer(op, 8, got);
        u_serial_master.stop();
    endtask
    task automatic status_read_cmd(input int pause_at);
        u_serial_master.start();
        u_serial_master.xfer(8'h05, 8, got);
        u_serial_master.xfer(8'h00, pause_at, got);
        u_serial_master.stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < WC + 50 && busy !== 1'b0; i++) tick(1);
    endtask
    task automatic swr(input logic [7:0] data, input logic mid);
        cmd1(8'h0E);
        u_serial_master.start();
        u_serial_master.xfer(8'h01, 8, got);
        u_serial_master.xfer(data, 8, got);
        if (mid) pin(1'b0);
        u_serial_master.stop();
    endtask
    task automatic pw(input logic pre, mid, post, input logic [7:0] data, exp);
        pin(pre);
        swr(data, mid);
        pin(post);
        wait_idle();
        chk8("status", exp, status);
        chk8("level", {6'h00, exp[3:2]}, {6'h00, level});
    endtask
    initial begin
        tick(10);
        i_rst = 1'b0;
        tick(4);
        chk8("status", 8'h00, status);
        chk1("oe_n", 1'b1, sdo_oe_n);
        for (int k = 0; k < 2; k++) begin
            cmd1(8'h06 | 8'(k << 3));
            chk8("status", 8'h02, status);
            status_read_cmd(8);
            chk8("status_read_cmd", 8'h02, got);
            chk1("drove", 1'b1, u_serial_master.drove);
            pin(1'b0);
            cmd1(8'h04 | 8'(k << 3));
            chk8("status", 8'h00, status);
            pin(1'b1);
        end
        swr(8'h8C, 1'b0);
        chk1("busy", 1'b1, busy);
        status_read_cmd(8);
        chk8("status_read_cmd busy", 8'hFF, got);
        cmd1(8'h06);
        wait_idle();
        chk8("status", 8'h8C, status);
        pw(1'b1, 1'b1, 1'b0, 8'h00, 8'h8E);
        pw(1'b0, 1'b0, 1'b0, 8'h00, 8'h8E);
        pw(1'b1, 1'b0, 1'b0, 8'h84, 8'h84);
        pw(1'b1, 1'b0, 1'b0, 8'h08, 8'h08);
        pw(1'b0, 1'b0, 1'b1, 8'h4C, 8'h0C);
        foreach (bad_op[k]) begin
            u_serial_master.start();
            u_serial_master.xfer(bad_op[k], 8, got);
            u_serial_master.xfer(8'h00, 8, got);
            u_serial_master.stop();
            chk1("drove", 1'b0, u_serial_master.drove);
        end
        status_read_cmd(4);
        chk8("status_read_cmd pause", 8'h0C, got);
        cmd1(8'h06);
        u_serial_master.start();
        u_serial_master.xfer(8'h02, 8, got);
        chk1("array_write", 1'b1, array_write);
        i_rx_ready = 1'b0;
        u_serial_master.xfer(8'hA5, 8, got);
        u_serial_master.xfer(8'h3C, 8, got);
        tick(8);
        foreach (rx_exp[k]) begin
            chk1("rx_valid", 1'b1, rx_valid);
            chk8("rx_data", rx_exp[k], rx_data);
            i_rx_ready = 1'b1;
            tick(1);
            i_rx_ready = 1'b0;
            tick(1);
        end
        chk1("rx_valid", 1'b0, rx_valid);
        i_rx_ready = 1'b1;
        u_serial_master.stop();
        wait_idle();
        u_serial_master.start();
        u_serial_master.xfer(8'h0B, 8, got);
        chk1("array_read", 1'b1, array_read);
        u_serial_master.stop();
        chk1("array_read", 1'b0, array_read);
        end_sim();
    end
endmodule
`default_nettype wire
